//--- cos_status.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "cos_cfg.svh"
module cos_status #(
  parameter int TICK_CYCLES = `COS_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire cos_pkg::cos_addr_t addr,
  input wire cos_pkg::cos_data_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output cos_pkg::cos_data_t rdata,
  input wire cos_pkg::cos_phase_t phase_start,
  input wire cos_pkg::cos_phase_t phase_trip,
  input wire cos_pkg::cos_word_t fault_current,
  input wire logic fault_current_stb,
  output cos_pkg::cos_phase_t phase_alarm_flag,
  output logic combined_start_flag,
  output cos_pkg::cos_phase_t phase_fault_flag,
  output logic combined_trip_flag,
  output cos_pkg::cos_word_t event_pulse,
  output cos_pkg::cos_word_t last_fault_current,
  output logic irq
);
  import cos_pkg::*;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // One spare tick on load: the tick phase at release is unknown, so a hold
  // lasts the full delay and at most one second more, never less
  localparam int HOLD_W = $bits(cos_word_t) + 1;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);

  function automatic logic [HOLD_W-1:0] hold_cnt(input logic present,
    input logic [HOLD_W-1:0] cnt, input cos_word_t dly, input logic tick);
    if (present) begin
      if (dly == `COS_DLY_RST) begin
        return HOLD_ZERO;
      end
      return HOLD_W'(dly) + HOLD_ONE;
    end else if (tick && cnt != HOLD_ZERO) begin
      return cnt - HOLD_ONE;
    end
    return cnt;
  endfunction : hold_cnt

  function automatic logic hold_flag(input logic present, input logic flag,
    input logic [HOLD_W-1:0] cnt_nxt);
    return present | (flag & (cnt_nxt != HOLD_ZERO));
  endfunction : hold_flag

  // Seconds tick shared by all hold counters
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = 32'h0000_0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Software registers
  logic [`COS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  cos_word_t alm_dly_r, alm_dly_nxt;
  cos_word_t flt_dly_r, flt_dly_nxt;
  cos_word_t mask_r, mask_nxt;
  cos_word_t last_r, last_nxt;
  logic repeat_en;

  assign repeat_en = ctrl_r[`COS_CTRL_REPEAT];

  always_comb begin
    ctrl_nxt = ctrl_r;
    alm_dly_nxt = alm_dly_r;
    flt_dly_nxt = flt_dly_r;
    mask_nxt = mask_r;
    last_nxt = last_r;
    if (wr_stb) begin
      case (addr)
        `COS_OFS_CTRL: ctrl_nxt = wdata[`COS_CTRL_W-1:0];
        `COS_OFS_ALM_DLY: alm_dly_nxt = wdata[15:0];
        `COS_OFS_FLT_DLY: flt_dly_nxt = wdata[15:0];
        `COS_OFS_EVT_MASK: mask_nxt = wdata[15:0];
        `COS_OFS_LAST_CUR: last_nxt = wdata[15:0];
        default: ;
      endcase
    end
    // A capture from the stages beats a software write in the same cycle
    if (fault_current_stb) begin
      last_nxt = fault_current;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_r <= `COS_CTRL_RST;
      alm_dly_r <= `COS_DLY_RST;
      flt_dly_r <= `COS_DLY_RST;
      mask_r <= `COS_EVT_RST;
      last_r <= `COS_WORD_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      alm_dly_r <= alm_dly_nxt;
      flt_dly_r <= flt_dly_nxt;
      mask_r <= mask_nxt;
      last_r <= last_nxt;
    end
  end

  // Per-phase hold counters, flags and event qualification
  logic [HOLD_W-1:0] alm_cnt_r [3];
  logic [HOLD_W-1:0] alm_cnt_nxt [3];
  logic [HOLD_W-1:0] flt_cnt_r [3];
  logic [HOLD_W-1:0] flt_cnt_nxt [3];
  cos_phase_t alm_r, alm_nxt, flt_r, flt_nxt;
  cos_phase_t alm_rep_r, alm_rep_nxt, flt_rep_r, flt_rep_nxt;
  cos_phase_t pa_on, pa_off, pf_on, pf_off;
  logic cs_r, cs_nxt, ct_r, ct_nxt;

  // Shared tick: a hold may run up to one second late, never early
  for (genvar g = 0; g < 3; g++) begin : g_phase
    always_comb begin
      alm_cnt_nxt[g] = hold_cnt(phase_start[g], alm_cnt_r[g], alm_dly_r,
        tick_r);
      flt_cnt_nxt[g] = hold_cnt(phase_trip[g], flt_cnt_r[g], flt_dly_r,
        tick_r);
      alm_nxt[g] = hold_flag(phase_start[g], alm_r[g], alm_cnt_nxt[g]);
      flt_nxt[g] = hold_flag(phase_trip[g], flt_r[g], flt_cnt_nxt[g]);
      // Repeat off: only phases that rise while no phase is active report, and their
      // Off event is kept so the logger always sees On/Off in pairs
      pa_on[g] = alm_nxt[g] & ~alm_r[g] & ctrl_r[`COS_CTRL_PA_ON]
        & (repeat_en | ~cs_r);
      pa_off[g] = ~alm_nxt[g] & alm_r[g] & ctrl_r[`COS_CTRL_PA_OFF]
        & (repeat_en | alm_rep_r[g]);
      pf_on[g] = flt_nxt[g] & ~flt_r[g] & ctrl_r[`COS_CTRL_PF_ON]
        & (repeat_en | ~ct_r);
      pf_off[g] = ~flt_nxt[g] & flt_r[g] & ctrl_r[`COS_CTRL_PF_OFF]
        & (repeat_en | flt_rep_r[g]);
      alm_rep_nxt[g] = alm_nxt[g] & (alm_rep_r[g] | pa_on[g]);
      flt_rep_nxt[g] = flt_nxt[g] & (flt_rep_r[g] | pf_on[g]);
    end

    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        alm_cnt_r[g] <= HOLD_ZERO;
        flt_cnt_r[g] <= HOLD_ZERO;
      end else begin
        alm_cnt_r[g] <= alm_cnt_nxt[g];
        flt_cnt_r[g] <= flt_cnt_nxt[g];
      end
    end

    chk_alarm_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      phase_start[g] |=> alm_r[g])
      else $error("alarm flag low after a start");
    chk_fault_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      phase_trip[g] |=> flt_r[g])
      else $error("fault flag low after a trip");
    chk_alarm_release: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $fell(alm_r[g]) |-> !$past(phase_start[g]) &&
      alm_cnt_r[g] == HOLD_ZERO)
      else $error("alarm flag fell before its delay ran out");
    chk_fault_release: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $fell(flt_r[g]) |-> !$past(phase_trip[g]) &&
      flt_cnt_r[g] == HOLD_ZERO)
      else $error("fault flag fell before its delay ran out");
    chk_pa_on_gate: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      event_pulse[`COS_EV_PA_ON+g] |-> $rose(alm_r[g]) &&
      $past(ctrl_r[`COS_CTRL_PA_ON]))
      else $error("alarm On event without enabled rise");
    chk_alarm_rise_seen: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(alm_r[g]) && $past(ctrl_r[`COS_CTRL_PA_ON]) && $past(repeat_en)
      |-> event_pulse[`COS_EV_PA_ON+g])
      else $error("enabled alarm rise gave no On event");
    chk_pa_off_gate: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      event_pulse[`COS_EV_PA_OFF+g] |-> $fell(alm_r[g]) &&
      $past(ctrl_r[`COS_CTRL_PA_OFF]))
      else $error("alarm Off event without enabled fall");
    chk_pf_gate: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (event_pulse[`COS_EV_PF_ON+g] |-> $rose(flt_r[g]) &&
      $past(ctrl_r[`COS_CTRL_PF_ON])) and
      (event_pulse[`COS_EV_PF_OFF+g] |-> $fell(flt_r[g]) &&
      $past(ctrl_r[`COS_CTRL_PF_OFF])))
      else $error("fault event without enabled transition");
    chk_repeat_gate: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !$past(repeat_en) && event_pulse[`COS_EV_PF_ON+g] |-> !$past(ct_r))
      else $error("repeated fault event while suppressed");
  end

  always_comb begin
    cs_nxt = |alm_nxt;
    ct_nxt = |flt_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      alm_r <= `COS_PH_RST;
      flt_r <= `COS_PH_RST;
      alm_rep_r <= `COS_PH_RST;
      flt_rep_r <= `COS_PH_RST;
      cs_r <= 1'b0;
      ct_r <= 1'b0;
    end else begin
      alm_r <= alm_nxt;
      flt_r <= flt_nxt;
      alm_rep_r <= alm_rep_nxt;
      flt_rep_r <= flt_rep_nxt;
      cs_r <= cs_nxt;
      ct_r <= ct_nxt;
    end
  end

  // Events, sticky status, interrupt and read data
  cos_word_t ev_r, ev_nxt, stat_r, stat_nxt;
  cos_data_t rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  always_comb begin
    ev_nxt = `COS_EVT_RST;
    ev_nxt[`COS_EV_PA_ON +: 3] = pa_on;
    ev_nxt[`COS_EV_PA_OFF +: 3] = pa_off;
    ev_nxt[`COS_EV_PF_ON +: 3] = pf_on;
    ev_nxt[`COS_EV_PF_OFF +: 3] = pf_off;
    ev_nxt[`COS_EV_CS_ON] = cs_nxt & ~cs_r
      & ctrl_r[`COS_CTRL_CS_ON];
    ev_nxt[`COS_EV_CS_OFF] = ~cs_nxt & cs_r
      & ctrl_r[`COS_CTRL_CS_OFF];
    ev_nxt[`COS_EV_CT_ON] = ct_nxt & ~ct_r
      & ctrl_r[`COS_CTRL_CT_ON];
    ev_nxt[`COS_EV_CT_OFF] = ~ct_nxt & ct_r
      & ctrl_r[`COS_CTRL_CT_OFF];
    // Read clears, but an event in the same cycle still lands
    stat_nxt = stat_r;
    if (rd_stb && addr == `COS_OFS_EVT_STAT) begin
      stat_nxt = `COS_EVT_RST;
    end
    stat_nxt = stat_nxt | ev_nxt;
    irq_nxt = |(stat_nxt & mask_r);
    rdata_nxt = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        `COS_OFS_CTRL: rdata_nxt[`COS_CTRL_W-1:0] = ctrl_r;
        `COS_OFS_ALM_DLY: rdata_nxt[15:0] = alm_dly_r;
        `COS_OFS_FLT_DLY: rdata_nxt[15:0] = flt_dly_r;
        `COS_OFS_FLAGS: begin
          rdata_nxt[`COS_FLG_ALM +: 3] = alm_r;
          rdata_nxt[`COS_FLG_CS] = cs_r;
          rdata_nxt[`COS_FLG_FLT +: 3] = flt_r;
          rdata_nxt[`COS_FLG_CT] = ct_r;
        end
        `COS_OFS_LAST_CUR: rdata_nxt[15:0] = last_r;
        `COS_OFS_EVT_STAT: rdata_nxt[15:0] = stat_r;
        `COS_OFS_EVT_MASK: rdata_nxt[15:0] = mask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ev_r <= `COS_EVT_RST;
      stat_r <= `COS_EVT_RST;
      irq_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ev_r <= ev_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign phase_alarm_flag = alm_r;
  assign combined_start_flag = cs_r;
  assign phase_fault_flag = flt_r;
  assign combined_trip_flag = ct_r;
  assign event_pulse = ev_r;
  assign last_fault_current = last_r;
  assign irq = irq_r;

  chk_start_or: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    combined_start_flag == |phase_alarm_flag)
    else $error("combined start differs from phase alarms");
  chk_trip_or: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    combined_trip_flag == |phase_fault_flag)
    else $error("combined trip differs from phase faults");
  chk_cs_events: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (event_pulse[`COS_EV_CS_ON] |-> $rose(cs_r) &&
    $past(ctrl_r[`COS_CTRL_CS_ON])) and
    (event_pulse[`COS_EV_CS_OFF] |-> $fell(cs_r) &&
    $past(ctrl_r[`COS_CTRL_CS_OFF])))
    else $error("combined start event without enabled edge");
  chk_ct_events: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (event_pulse[`COS_EV_CT_ON] |-> $rose(ct_r) &&
    $past(ctrl_r[`COS_CTRL_CT_ON])) and
    (event_pulse[`COS_EV_CT_OFF] |-> $fell(ct_r) &&
    $past(ctrl_r[`COS_CTRL_CT_OFF])))
    else $error("combined trip event without enabled edge");
  chk_ct_rise_seen: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(ct_r) && $past(ctrl_r[`COS_CTRL_CT_ON])
    |-> event_pulse[`COS_EV_CT_ON])
    else $error("enabled combined trip rise gave no event");
  chk_ct_fall_seen: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(ct_r) && $past(ctrl_r[`COS_CTRL_CT_OFF])
    |-> event_pulse[`COS_EV_CT_OFF])
    else $error("enabled combined trip fall gave no event");
  chk_event_single: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    event_pulse[`COS_EV_CS_ON] |=> !event_pulse[`COS_EV_CS_ON])
    else $error("combined start On event longer than one cycle");
  chk_last_capture: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fault_current_stb |=>
    last_fault_current == $past(fault_current))
    else $error("fault current not captured");
  chk_last_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_stb && addr == `COS_OFS_LAST_CUR && !fault_current_stb
    |=> last_fault_current == $past(wdata[15:0]))
    else $error("fault current write lost");
  chk_alarm_dly_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_stb && addr == `COS_OFS_ALM_DLY
    |=> alm_dly_r == $past(wdata[15:0]))
    else $error("alarm delay write lost");
  chk_fault_dly_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    wr_stb && addr == `COS_OFS_FLT_DLY
    |=> flt_dly_r == $past(wdata[15:0]))
    else $error("fault delay write lost");
endmodule : cos_status

//--- cos_cfg.svh
`ifndef COS_CFG_SVH
`define COS_CFG_SVH

`define COS_CLK_HZ 25000000
`define COS_TICK_S 1
`define COS_TICK_CYC (`COS_TICK_S * `COS_CLK_HZ)

`define COS_OFS_CTRL 8'h00
`define COS_OFS_ALM_DLY 8'h04
`define COS_OFS_FLT_DLY 8'h08
`define COS_OFS_FLAGS 8'h0C
`define COS_OFS_LAST_CUR 8'h10
`define COS_OFS_EVT_STAT 8'h14
`define COS_OFS_EVT_MASK 8'h18

`define COS_CTRL_PA_ON 0
`define COS_CTRL_PA_OFF 1
`define COS_CTRL_CS_ON 2
`define COS_CTRL_CS_OFF 3
`define COS_CTRL_PF_ON 4
`define COS_CTRL_PF_OFF 5
`define COS_CTRL_CT_ON 6
`define COS_CTRL_CT_OFF 7
`define COS_CTRL_REPEAT 8
`define COS_CTRL_W 9
`define COS_CTRL_RST 9'h1FF

`define COS_EV_PA_ON 0
`define COS_EV_PA_OFF 3
`define COS_EV_CS_ON 6
`define COS_EV_CS_OFF 7
`define COS_EV_PF_ON 8
`define COS_EV_PF_OFF 11
`define COS_EV_CT_ON 14
`define COS_EV_CT_OFF 15

`define COS_FLG_ALM 0
`define COS_FLG_CS 3
`define COS_FLG_FLT 4
`define COS_FLG_CT 7

`define COS_DLY_RST 16'h0000
`define COS_WORD_RST 16'h0000
`define COS_EVT_RST 16'h0000
`define COS_PH_RST 3'h0

`endif

//--- cos_pkg.sv
package cos_pkg;
  typedef logic [15:0] cos_word_t;
  typedef logic [2:0] cos_phase_t;
  typedef logic [7:0] cos_addr_t;
  typedef logic [31:0] cos_data_t;
endpackage : cos_pkg

//--- cos_stage_model.sv
`timescale 1ns/100ps
module cos_stage_model (
  input wire logic sys_clk,
  input wire cos_pkg::cos_word_t event_pulse,
  output cos_pkg::cos_phase_t phase_start,
  output cos_pkg::cos_phase_t phase_trip,
  output cos_pkg::cos_word_t fault_current,
  output logic fault_current_stb
);
  import cos_pkg::*;
  logic [31:0] ev_cnt [16];
  initial begin
    phase_start = 3'h0;
    phase_trip = 3'h0;
    fault_current = 16'h0000;
    fault_current_stb = 1'b0;
    clear_counts();
  end
  // Stages report start and trip as levels
  task automatic drive(input cos_phase_t s, input cos_phase_t t);
    @(posedge sys_clk);
    phase_start <= s;
    phase_trip <= t;
  endtask : drive
  // Current is only meaningful with the strobe; inverted after it
  task automatic capture(input cos_word_t c);
    @(posedge sys_clk);
    fault_current <= c;
    fault_current_stb <= 1'b1;
    @(posedge sys_clk);
    fault_current_stb <= 1'b0;
    fault_current <= ~c;
  endtask : capture
  task automatic clear_counts();
    for (int j = 0; j < 16; j++) begin
      ev_cnt[j] = 32'h0;
    end
  endtask : clear_counts
  // Recorder counts pulses, so a doubled event shows as two
  always @(posedge sys_clk) begin
    for (int j = 0; j < 16; j++) begin
      if (event_pulse[j] === 1'b1) begin
        ev_cnt[j] <= ev_cnt[j] + 32'h1;
      end
    end
  end
endmodule : cos_stage_model

//--- cos_status_bench.sv
`timescale 1ns/100ps
`include "cos_cfg.svh"
module cos_status_bench;
  import cos_pkg::*;
  localparam int TICK = 10;
  logic sys_clk;
  logic reset_n;
  cos_addr_t addr;
  cos_data_t wdata;
  logic wr_stb;
  logic rd_stb;
  cos_data_t rdata;
  cos_phase_t phase_start;
  cos_phase_t phase_trip;
  cos_word_t fault_current;
  logic fault_current_stb;
  cos_phase_t phase_alarm_flag;
  logic combined_start_flag;
  cos_phase_t phase_fault_flag;
  logic combined_trip_flag;
  cos_word_t event_pulse;
  cos_word_t last_fault_current;
  logic irq;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [8:0] ctrl_tab [4] = '{9'h1FF, 9'h155, 9'h1AA, 9'h100};
  logic [8:0] rep_tab [2] = '{9'h0FF, 9'h1FF};
  cos_word_t rep_exp [2] = '{16'hC9C9, 16'hDBDB};

  cos_status #(.TICK_CYCLES(TICK)) dut (.sys_clk, .reset_n, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .phase_start, .phase_trip, .fault_current,
    .fault_current_stb, .phase_alarm_flag, .combined_start_flag,
    .phase_fault_flag, .combined_trip_flag, .event_pulse,
    .last_fault_current, .irq);
  cos_stage_model model (.sys_clk, .event_pulse, .phase_start, .phase_trip,
    .fault_current, .fault_current_stb);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // Long enough for the whole sequence, short enough to cut a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string name, input cos_data_t exp,
                     input cos_data_t got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cycles

  task automatic wr(input cos_addr_t a, input cos_data_t d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input cos_addr_t a, input cos_data_t exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask : rd

  function automatic cos_word_t exp_ev(input logic [8:0] c, input int i);
    cos_word_t e;
    e = 16'h0000;
    e[i] = c[0];
    e[3 + i] = c[1];
    e[6] = c[2];
    e[7] = c[3];
    e[8 + i] = c[4];
    e[11 + i] = c[5];
    e[14] = c[6];
    e[15] = c[7];
    return e;
  endfunction : exp_ev

  task automatic chk_ev(input cos_word_t m);
    for (int j = 0; j < 16; j++) begin
      chk("event count", {31'h0, m[j]}, model.ev_cnt[j]);
    end
  endtask : chk_ev

  function automatic cos_data_t flags();
    return {24'h0, combined_trip_flag, phase_fault_flag,
            combined_start_flag, phase_alarm_flag};
  endfunction : flags

  // One phase starts and trips, then releases, with zero clear delay
  task automatic pulse(input logic [8:0] c, input int i);
    cos_phase_t p;
    p = 3'h1 << i;
    model.clear_counts();
    model.drive(p, p);
    cycles(2);
    chk("flags set", {24'h0, 1'b1, p, 1'b1, p}, flags());
    model.drive(3'h0, 3'h0);
    cycles(4);
    chk("flags clear", 32'h0, flags());
    chk_ev(exp_ev(c, i));
  endtask : pulse

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 32; a += 4) begin
      rd(8'(a), (a == 0) ? 32'h1FF : 32'h0);
    end
    wr(`COS_OFS_ALM_DLY, 32'hFFFF);
    rd(`COS_OFS_ALM_DLY, 32'h0000FFFF);
    wr(`COS_OFS_FLT_DLY, 32'hFFFF);
    rd(`COS_OFS_FLT_DLY, 32'h0000FFFF);
    wr(`COS_OFS_ALM_DLY, 32'h0);
    wr(`COS_OFS_FLT_DLY, 32'h0);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 3; i++) begin
        wr(`COS_OFS_CTRL, {23'h0, ctrl_tab[k]});
        pulse(ctrl_tab[k], i);
      end
    end
    // Second phase joins while the first is still active
    for (int k = 0; k < 2; k++) begin
      wr(`COS_OFS_CTRL, {23'h0, rep_tab[k]});
      model.clear_counts();
      model.drive(3'h1, 3'h1);
      cycles(3);
      model.drive(3'h3, 3'h3);
      cycles(3);
      model.drive(3'h0, 3'h0);
      cycles(4);
      chk_ev(rep_exp[k]);
    end
    // Hold times: tick granularity gives up to one tick (TICK, 10 cycles here) of slack
    wr(`COS_OFS_ALM_DLY, 32'h3);
    wr(`COS_OFS_FLT_DLY, 32'h1);
    model.drive(3'h4, 3'h4);
    cycles(3);
    rd(`COS_OFS_FLAGS, 32'h000000CC);
    model.drive(3'h0, 3'h0);
    cycles(24);
    chk("alarm held", 32'h0000000C, flags());
    cycles(22);
    chk("alarm expired", 32'h0, flags());
    wr(`COS_OFS_ALM_DLY, 32'h0);
    wr(`COS_OFS_FLT_DLY, 32'h0);
    model.capture(16'h1234);
    cycles(1);
    chk("last current", 32'h1234, {16'h0, last_fault_current});
    rd(`COS_OFS_LAST_CUR, 32'h00001234);
    wr(`COS_OFS_LAST_CUR, 32'h00000055);
    rd(`COS_OFS_LAST_CUR, 32'h00000055);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`COS_OFS_EVT_MASK, 32'h0001);
    cycles(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(`COS_OFS_EVT_STAT, 32'h0000FFFF);
    cycles(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(`COS_OFS_EVT_STAT, 32'h0);
    pulse(9'h1FF, 0);
    chk("irq again", 32'h1, {31'h0, irq});
    summarize();
  end
endmodule : cos_status_bench
